// File: logic/vdh_pkg.sv
// Purpose: shared constants and carriers for the video decoder host control block
// Assumes: byte-wide register port behind the serial register interface
// Notes:   offsets are byte sub-addresses of that port
package vdh_pkg;

    localparam logic [7:0] OFS_IRQ_CLEAR   = 8'h1C;
    localparam logic [7:0] OFS_IRQ_MASK    = 8'h1D;
    localparam logic [7:0] OFS_IRQ_CFG     = 8'h1E;
    localparam logic [7:0] OFS_IND_LO      = 8'h21;
    localparam logic [7:0] OFS_IND_HI      = 8'h22;
    localparam logic [7:0] OFS_IND_ADDR    = 8'h23;
    localparam logic [7:0] OFS_IND_STROBE  = 8'h24;
    localparam logic [7:0] OFS_STD_SEL     = 8'h28;
    localparam logic [7:0] OFS_BLUE_GAIN   = 8'h2C;
    localparam logic [7:0] OFS_RED_GAIN    = 8'h2D;
    localparam logic [7:0] OFS_CP_ON       = 8'h2E;
    localparam logic [7:0] OFS_CP_OFF      = 8'h2F;
    localparam logic [7:0] OFS_TIMING_REV  = 8'h30;
    localparam logic [7:0] OFS_PATCH_LOAD  = 8'h7E;
    localparam logic [7:0] OFS_PATCH_RUN   = 8'h7F;
    localparam logic [7:0] OFS_IDENT_HI    = 8'h80;
    localparam logic [7:0] OFS_IDENT_LO    = 8'h81;
    localparam logic [7:0] OFS_IRQ_STATUS  = 8'h86;
    localparam logic [7:0] OFS_IRQ_ACTIVE  = 8'h87;

    // bit 5 of mask and status is reserved
    localparam logic [7:0] IRQ_VALID_BITS  = 8'hDF;
    localparam int         IRQ_CP_BIT      = 6;
    localparam logic [7:0] RST_MASK        = 8'h00;
    localparam logic       RST_POL         = 1'b0;
    localparam logic [3:0] RST_STD         = 4'h0;
    localparam logic [7:0] RST_CP_ON       = 8'h0F;
    localparam logic [7:0] RST_CP_OFF      = 8'h01;

    localparam logic [7:0] OP_RD_BANK0     = 8'h01;
    localparam logic [7:0] OP_WR_BANK0     = 8'h02;
    localparam logic [7:0] OP_RD_BANK2     = 8'h03;
    localparam logic [7:0] OP_WR_BANK2     = 8'h04;
    localparam logic [7:0] OP_RD_BANK3     = 8'h05;
    localparam logic [7:0] OP_WR_BANK3     = 8'h06;
    localparam logic [1:0] BANK_LOW        = 2'h0;
    localparam logic [1:0] BANK_200        = 2'h2;
    localparam logic [1:0] BANK_300        = 2'h3;

    // arbitrary identification values, not tied to any real part
    localparam logic [7:0] IDENT_HI_VAL    = 8'hA5;
    localparam logic [7:0] IDENT_LO_VAL    = 8'h3C;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } vdh_regreq_t;

    typedef struct packed {
        logic        req;
        logic        we;
        logic [9:0]  addr;
        logic [15:0] wdata;
    } vdh_ind_t;

    typedef enum logic [1:0] {
        IND_IDLE = 2'b01,
        IND_BUSY = 2'b10
    } vdh_ind_state_t;

endpackage : vdh_pkg

// File: logic/vdh_host_regs.sv
// Purpose: host-visible control registers: interrupt B channel, indirect access,
//          standard forcing, copy-protection counters, patch control, identity
// Assumes: register port and decoder-side inputs share clk_sys
// Notes:   register reads answer two cycles later, or after a pending indirect op
`timescale 1ns/1ps

module vdh_host_regs
    import vdh_pkg::*;
(
    input  wire logic        clk_sys,
    input  wire logic        rst_n,
    input  wire vdh_regreq_t reg_req,
    output logic [7:0]       reg_rdata,
    output logic             reg_rvalid,
    input  wire logic [7:0]  irq_events,
    input  wire logic [7:0]  blue_difference_chroma_gain,
    input  wire logic [7:0]  red_difference_chroma_gain,
    input  wire logic        cp_frame_tick,
    input  wire logic        cp_pulses_seen,
    output logic             cp_present,
    output vdh_ind_t         ind_port,
    input  wire logic        ind_ack,
    input  wire logic [15:0] ind_rdata,
    output logic [3:0]       std_select,
    output logic             std_forced,
    output logic             timing_rev_old,
    output logic             patch_wr,
    output logic [7:0]       patch_data,
    output logic             cpu_restart,
    output logic             irq_pin_o,
    output logic             irq_pin_oe
);

    typedef struct packed {
        logic [7:0]     mask;
        logic           pol;
        logic [7:0]     status;
        logic           irq_act;
        logic           pin_o;
        logic           pin_oe;
        logic [7:0]     dlo;
        logic [7:0]     dhi;
        logic [7:0]     taddr;
        logic [7:0]     strobe;
        vdh_ind_state_t ist;
        vdh_ind_t       ind;
        logic [3:0]     std;
        logic           forced;
        logic [7:0]     cp_on;
        logic [7:0]     cp_off;
        logic [7:0]     cp_cnt;
        logic           cp_pres;
        logic           rev_old;
        logic           patch_loaded;
        logic           patch_wr;
        logic [7:0]     patch_data;
        logic           cpu_restart;
        logic           rd_pend;
        logic [7:0]     rd_addr;
        logic [7:0]     rdata;
        logic           rvalid;
    } vdh_state_t;

    vdh_state_t st;
    vdh_state_t next_st;
    logic [1:0] rst_q;
    logic       rst_sync_n;

    ////////////////////////////////////////////////////////////////////////////////
    // reset release
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rst_q <= 2'b00;
        end else begin
            rst_q <= {rst_q[0], 1'b1};
        end
    end
    assign rst_sync_n = rst_q[1];

    ////////////////////////////////////////////////////////////////////////////////
    // read decode
    function automatic logic [7:0] read_mux(input vdh_state_t s, input logic [7:0] a,
                                            input logic [7:0] bg, input logic [7:0] rg);
        logic [7:0] v;
        v = 8'h00;
        if (a == OFS_IRQ_MASK) begin
            v = s.mask;
        end else if (a == OFS_IRQ_CFG) begin
            v = {7'h00, s.pol};
        end else if (a == OFS_IND_LO) begin
            v = s.dlo;
        end else if (a == OFS_IND_HI) begin
            v = s.dhi;
        end else if (a == OFS_IND_ADDR) begin
            v = s.taddr;
        end else if (a == OFS_IND_STROBE) begin
            v = s.strobe;
        end else if (a == OFS_STD_SEL) begin
            v = {4'h0, s.std};
        end else if (a == OFS_BLUE_GAIN) begin
            v = bg;
        end else if (a == OFS_RED_GAIN) begin
            v = rg;
        end else if (a == OFS_CP_ON) begin
            v = s.cp_on;
        end else if (a == OFS_CP_OFF) begin
            v = s.cp_off;
        end else if (a == OFS_TIMING_REV) begin
            v = {7'h00, s.rev_old};
        end else if (a == OFS_IDENT_HI) begin
            v = IDENT_HI_VAL;
        end else if (a == OFS_IDENT_LO) begin
            v = IDENT_LO_VAL;
        end else if (a == OFS_IRQ_STATUS) begin
            v = s.status;
        end else if (a == OFS_IRQ_ACTIVE) begin
            v = {7'h00, s.irq_act};
        end
        return v;
    endfunction : read_mux

    ////////////////////////////////////////////////////////////////////////////////
    // next state
    always_comb begin
        logic       wr_ok;
        logic [7:0] thr;
        logic       cp_flip;
        next_st            = st;
        next_st.patch_wr   = 1'b0;
        next_st.cpu_restart = 1'b0;
        next_st.rvalid     = 1'b0;
        wr_ok              = reg_req.wr && (st.ist == IND_IDLE);
        cp_flip            = 1'b0;
        thr                = 8'h00;

        // indirect completion; data bytes refreshed on reads only, before any deferred read
        if (st.ist == IND_BUSY && ind_ack) begin
            next_st.ind.req = 1'b0;
            next_st.ist     = IND_IDLE;
            if (!st.ind.we) begin
                next_st.dlo = ind_rdata[7:0];
                next_st.dhi = ind_rdata[15:8];
            end
        end

        // register writes; indirect group frozen while an op runs
        if (reg_req.wr) begin
            if (reg_req.addr == OFS_IRQ_MASK) begin
                next_st.mask = reg_req.wdata & IRQ_VALID_BITS;
            end else if (reg_req.addr == OFS_IRQ_CFG) begin
                next_st.pol = reg_req.wdata[0];
            end else if (reg_req.addr == OFS_IND_LO && wr_ok) begin
                next_st.dlo = reg_req.wdata;
            end else if (reg_req.addr == OFS_IND_HI && wr_ok) begin
                next_st.dhi = reg_req.wdata;
            end else if (reg_req.addr == OFS_IND_ADDR && wr_ok) begin
                next_st.taddr = reg_req.wdata;
            end else if (reg_req.addr == OFS_IND_STROBE && wr_ok) begin
                next_st.strobe = reg_req.wdata;
                next_st.ind.wdata = {st.dhi, st.dlo};
                next_st.ind.we = 1'b0;
                next_st.ind.req = 1'b1;
                next_st.ist = IND_BUSY;
                case (reg_req.wdata)
                    OP_RD_BANK0: next_st.ind.addr = {BANK_LOW, st.taddr};
                    OP_WR_BANK0: begin
                        next_st.ind.addr = {BANK_LOW, st.taddr};
                        next_st.ind.we = 1'b1;
                    end
                    OP_RD_BANK2: next_st.ind.addr = {BANK_200, st.taddr};
                    OP_WR_BANK2: begin
                        next_st.ind.addr = {BANK_200, st.taddr};
                        next_st.ind.we = 1'b1;
                    end
                    OP_RD_BANK3: next_st.ind.addr = {BANK_300, st.taddr};
                    OP_WR_BANK3: begin
                        next_st.ind.addr = {BANK_300, st.taddr};
                        next_st.ind.we = 1'b1;
                    end
                    default: begin
                        // undefined code: stored, no operation started
                        next_st.ind.req = 1'b0;
                        next_st.ist = IND_IDLE;
                    end
                endcase
            end else if (reg_req.addr == OFS_STD_SEL) begin
                if (!reg_req.wdata[0]) begin
                    next_st.std = reg_req.wdata[3:0];
                    next_st.forced = (reg_req.wdata[3:0] != RST_STD);
                end
            end else if (reg_req.addr == OFS_CP_ON) begin
                next_st.cp_on = reg_req.wdata;
            end else if (reg_req.addr == OFS_CP_OFF) begin
                next_st.cp_off = reg_req.wdata;
            end else if (reg_req.addr == OFS_TIMING_REV) begin
                next_st.rev_old = reg_req.wdata[0];
            end else if (reg_req.addr == OFS_PATCH_LOAD) begin
                next_st.patch_wr = 1'b1;
                next_st.patch_data = reg_req.wdata;
                next_st.patch_loaded = 1'b1;
            end else if (reg_req.addr == OFS_PATCH_RUN) begin
                // a stray run write without a load is ignored
                next_st.cpu_restart = st.patch_loaded;
                next_st.patch_loaded = 1'b0;
            end
        end

        // copy-protection debounce over frames; zero count acts as one
        if (cp_frame_tick) begin
            thr = cp_pulses_seen ? st.cp_on : st.cp_off;
            if (thr == 8'h00) begin
                thr = 8'h01;
            end
            if (cp_pulses_seen == st.cp_pres) begin
                next_st.cp_cnt = 8'h00;
            end else if (st.cp_cnt + 8'h01 >= thr) begin
                next_st.cp_pres = cp_pulses_seen;
                next_st.cp_cnt = 8'h00;
                cp_flip = 1'b1;
            end else begin
                next_st.cp_cnt = st.cp_cnt + 8'h01;
            end
        end

        // status: clear by write-one, event set wins over the clear
        if (reg_req.wr && reg_req.addr == OFS_IRQ_CLEAR) begin
            next_st.status = st.status & ~reg_req.wdata;
        end
        next_st.status = next_st.status | (irq_events & IRQ_VALID_BITS);
        next_st.status[IRQ_CP_BIT] = next_st.status[IRQ_CP_BIT] | cp_flip;

        // pin follows status and mask of the same cycle
        next_st.irq_act = |(next_st.status & next_st.mask);
        if (next_st.pol) begin
            next_st.pin_o = next_st.irq_act;
            next_st.pin_oe = 1'b1;
        end else begin
            next_st.pin_o = 1'b0;
            next_st.pin_oe = next_st.irq_act;
        end

        // reads wait for a running indirect op to finish
        if (reg_req.rd) begin
            next_st.rd_pend = 1'b1;
            next_st.rd_addr = reg_req.addr;
        end
        if (st.rd_pend && st.ist == IND_IDLE) begin
            next_st.rd_pend = reg_req.rd;
            next_st.rdata = read_mux(st, st.rd_addr, blue_difference_chroma_gain,
                                     red_difference_chroma_gain);
            next_st.rvalid = 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // state register
    always_ff @(posedge clk_sys or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            st <= '{mask: RST_MASK, pol: RST_POL, std: RST_STD, cp_on: RST_CP_ON,
                    cp_off: RST_CP_OFF, ist: IND_IDLE, default: '0};
        end else begin
            st <= next_st;
        end
    end

    assign reg_rdata      = st.rdata;
    assign reg_rvalid     = st.rvalid;
    assign cp_present     = st.cp_pres;
    assign ind_port       = st.ind;
    assign std_select     = st.std;
    assign std_forced     = st.forced;
    assign timing_rev_old = st.rev_old;
    assign patch_wr       = st.patch_wr;
    assign patch_data     = st.patch_data;
    assign cpu_restart    = st.cpu_restart;
    assign irq_pin_o      = st.pin_o;
    assign irq_pin_oe     = st.pin_oe;

    ////////////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_sync_n);

    property p_mask_block;
        ((st.status & st.mask) == 8'h00) |-> ((irq_pin_oe == st.pol) && !irq_pin_o);
    endproperty
    a_mask_block: assert property (p_mask_block) else $error("masked source reached pin");

    property p_irq_exact;
        (irq_pin_oe && (irq_pin_o == st.pol)) == (|(st.status & st.mask));
    endproperty
    a_irq_exact: assert property (p_irq_exact) else $error("pin state not status and mask");

    property p_status_unmasked;
        (irq_events[0] && !st.mask[0]) |=> st.status[0];
    endproperty
    a_status_unmasked: assert property (p_status_unmasked) else $error("status not set");

    property p_open_drain;
        !st.pol |-> (!st.pin_o && (st.pin_oe == st.irq_act));
    endproperty
    a_open_drain: assert property (p_open_drain) else $error("active low drive wrong");

    property p_push_pull;
        st.pol |-> (st.pin_oe && (st.pin_o == st.irq_act));
    endproperty
    a_push_pull: assert property (p_push_pull) else $error("active high drive wrong");

    property p_clear_one;
        (reg_req.wr && reg_req.addr == OFS_IRQ_CLEAR && reg_req.wdata[1] && !irq_events[1])
            |=> !st.status[1];
    endproperty
    a_clear_one: assert property (p_clear_one) else $error("status bit not cleared");

    sequence s_write_strobe;
        reg_req.wr && reg_req.addr == OFS_IND_STROBE && reg_req.wdata == OP_WR_BANK2
            && st.ist == IND_IDLE;
    endsequence
    property p_strobe_write;
        s_write_strobe |=> (ind_port.req && ind_port.we && ind_port.addr[9:8] == BANK_200);
    endproperty
    a_strobe_write: assert property (p_strobe_write) else $error("indirect write not started");

    sequence s_read_done;
        st.ist == IND_BUSY && !st.ind.we && ind_ack;
    endsequence
    property p_read_lands;
        s_read_done |=> ({st.dhi, st.dlo} == $past(ind_rdata)) && !ind_port.req;
    endproperty
    a_read_lands: assert property (p_read_lands) else $error("indirect data not loaded");

    property p_ident;
        (reg_req.rd && reg_req.addr == OFS_IDENT_HI && !st.rd_pend && st.ist == IND_IDLE)
            |=> ##1 (reg_rvalid && reg_rdata == IDENT_HI_VAL);
    endproperty
    a_ident: assert property (p_ident) else $error("identity byte wrong");

    property p_active_read;
        (reg_req.rd && reg_req.addr == OFS_IRQ_ACTIVE && !st.rd_pend && st.ist == IND_IDLE)
            |=> ##1 (reg_rdata[0] == $past(st.irq_act));
    endproperty
    a_active_read: assert property (p_active_read) else $error("active bit wrong");

    property p_run_needs_load;
        (reg_req.wr && reg_req.addr == OFS_PATCH_RUN && !st.patch_loaded) |=> !cpu_restart;
    endproperty
    a_run_needs_load: assert property (p_run_needs_load) else $error("restart without load");

    property p_odd_std_kept;
        (reg_req.wr && reg_req.addr == OFS_STD_SEL && reg_req.wdata[0])
            |=> (std_select == $past(std_select));
    endproperty
    a_odd_std_kept: assert property (p_odd_std_kept) else $error("odd standard taken");

endmodule : vdh_host_regs

// File: testbench/vdh_ind_space.sv
// Purpose: model of the indirect register space behind the indirect port
// Assumes: one request at a time, held until acknowledged
// Notes:   latency set by the bench; read data scrambled outside an answer
`timescale 1ns/1ps
module vdh_ind_space
    import vdh_pkg::*;
(
    input  wire logic       clk_sys,
    input  wire logic       rst_n,
    input  wire vdh_ind_t   ind_port,
    input  wire logic [7:0] lat,
    output logic            ind_ack,
    output logic [15:0]     ind_rdata
);
    logic [15:0] mem [1024];
    logic [7:0]  cnt;
    ////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            cnt       <= 8'h00;
            ind_ack   <= 1'b0;
            ind_rdata <= 16'h0000;
        end else begin
            ind_ack <= 1'b0;
            if (ind_port.req && !ind_ack && cnt >= lat) begin
                ind_ack   <= 1'b1;
                cnt       <= 8'h00;
                ind_rdata <= mem[ind_port.addr];
                if (ind_port.we) begin
                    mem[ind_port.addr] <= ind_port.wdata;
                end
            end else begin
                cnt       <= (ind_port.req && !ind_ack) ? cnt + 8'h01 : 8'h00;
                // stale data must never pass for an answer
                ind_rdata <= ~ind_rdata;
            end
        end
    end
endmodule : vdh_ind_space

// File: testbench/vdh_host_regs_tb.sv
// Purpose: self-checking bench for the host control register block
// Assumes: bench plays the host; vdh_ind_space answers indirect requests
// Notes:   random values from an xorshift seeded at 70584
`timescale 1ns/1ps
module vdh_host_regs_tb;
    import vdh_pkg::*;
    logic        clk_sys = 1'b0;
    logic        rst_n = 1'b0;
    vdh_regreq_t reg_req = '0;
    logic [7:0]  irq_events = 8'h00, bg = 8'h00, rg = 8'h00, lat = 8'h00;
    logic        tick = 1'b0, seen = 1'b0;
    logic [7:0]  reg_rdata, patch_data, last_patch;
    logic        reg_rvalid, cp_present, ind_ack, std_forced, timing_rev_old;
    logic        patch_wr, cpu_restart, irq_pin_o, irq_pin_oe;
    logic [15:0] ind_rdata;
    logic [3:0]  std_select;
    vdh_ind_t    ind_port;
    int          n_errors = 0, comparisons = 0, cyc = 0, n_patch = 0, n_rst = 0;
    logic [31:0] seed = 32'h0001_13B8;
    localparam logic [7:0] RA[10] = '{OFS_IRQ_MASK, OFS_IRQ_CFG, OFS_IND_ADDR, OFS_STD_SEL,
        OFS_CP_ON, OFS_CP_OFF, OFS_TIMING_REV, OFS_IDENT_HI, OFS_IDENT_LO, 8'h55};
    localparam logic [7:0] RD[10] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h0F, 8'h01, 8'h00,
        IDENT_HI_VAL, IDENT_LO_VAL, 8'h00};
    ////////////////////////////////////////////////////////////////////////////
    vdh_host_regs u_dut (.clk_sys(clk_sys), .rst_n(rst_n), .reg_req(reg_req),
        .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .irq_events(irq_events),
        .blue_difference_chroma_gain(bg), .red_difference_chroma_gain(rg),
        .cp_frame_tick(tick), .cp_pulses_seen(seen), .cp_present(cp_present),
        .ind_port(ind_port), .ind_ack(ind_ack), .ind_rdata(ind_rdata),
        .std_select(std_select), .std_forced(std_forced), .timing_rev_old(timing_rev_old),
        .patch_wr(patch_wr), .patch_data(patch_data), .cpu_restart(cpu_restart),
        .irq_pin_o(irq_pin_o), .irq_pin_oe(irq_pin_oe));
    vdh_ind_space u_far (.clk_sys(clk_sys), .rst_n(rst_n), .ind_port(ind_port), .lat(lat),
        .ind_ack(ind_ack), .ind_rdata(ind_rdata));
    ////////////////////////////////////////////////////////////////////////////
    function automatic logic [7:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[7:0];
    endfunction : rnd
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        comparisons++;
        if (g !== e) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic final_report;
        $display("comparisons %0d n_errors %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : final_report
    task automatic wt(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask : wt
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge clk_sys);
        reg_req.wr <= 1'b0;
    endtask : wr
    // read waits on the answer; a busy indirect op may stretch it
    task automatic rc(input logic [7:0] a, input logic [7:0] e);
        int n = 0;
        @(posedge clk_sys);
        reg_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(posedge clk_sys);
        reg_req.rd <= 1'b0;
        do begin
            wt(1);
            n++;
        end while (reg_rvalid !== 1'b1 && n < 100);
        chk("reg_rvalid", 16'h0001, 16'(reg_rvalid));
        chk($sformatf("reg %h", a), 16'(e), 16'(reg_rdata));
    endtask : rc
    task automatic pin(input logic pol, input logic act);
        chk("irq_pin_oe", 16'(pol | act), 16'(irq_pin_oe));
        chk("irq_pin_o", 16'(pol & act), 16'(irq_pin_o));
    endtask : pin
    task automatic frame(input logic s);
        @(posedge clk_sys);
        seen <= s;
        tick <= 1'b1;
        @(posedge clk_sys);
        tick <= 1'b0;
        wt(2);
    endtask : frame
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        forever #20 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        cyc++;
        if (patch_wr === 1'b1) begin
            n_patch++;
            last_patch = patch_data;
        end
        if (cpu_restart === 1'b1) begin
            n_rst++;
        end
        if (cyc == 20000) begin
            n_errors++;
            final_report();
        end
    end
    initial begin
        logic [7:0]  m, e, c, s;
        logic [15:0] w [3];
        repeat (3) @(posedge clk_sys);
        rst_n <= 1'b1;
        bg <= rnd();
        rg <= rnd();
        repeat (4) @(posedge clk_sys);
        foreach (RA[i]) rc(RA[i], RD[i]);
        rc(OFS_BLUE_GAIN, bg);
        rc(OFS_RED_GAIN, rg);
        for (int i = 0; i < 6; i++) begin
            m = (i == 1) ? 8'hFF : rnd();
            e = rnd();
            wr(OFS_IRQ_CFG, {7'h00, i[0]});
            wr(OFS_IRQ_MASK, m);
            @(posedge clk_sys);
            irq_events <= e;
            @(posedge clk_sys);
            irq_events <= 8'h00;
            wt(2);
            rc(OFS_IRQ_STATUS, e & IRQ_VALID_BITS);
            pin(i[0], |(e & m & IRQ_VALID_BITS));
            rc(OFS_IRQ_ACTIVE, {7'h00, |(e & m & IRQ_VALID_BITS)});
            wr(OFS_IRQ_CLEAR, e & m);
            wt(2);
            rc(OFS_IRQ_STATUS, e & ~m & IRQ_VALID_BITS);
            pin(i[0], 1'b0);
            wr(OFS_IRQ_CLEAR, 8'hFF);
        end
        c = rnd();
        wr(OFS_IND_ADDR, c);
        for (int b = 0; b < 3; b++) begin
            w[b] = {rnd(), rnd()};
            lat <= rnd() & 8'h07;
            wr(OFS_IND_LO, w[b][7:0]);
            wr(OFS_IND_HI, w[b][15:8]);
            wr(OFS_IND_STROBE, 8'(2 * b + 2));
            rc(OFS_IND_ADDR, c);
        end
        for (int b = 0; b < 3; b++) begin
            lat <= 8'h03 + (rnd() & 8'h03);
            wr(OFS_IND_STROBE, 8'(2 * b + 1));
            wr(OFS_IND_LO, 8'hEE);
            rc(OFS_IND_LO, w[b][7:0]);
            rc(OFS_IND_HI, w[b][15:8]);
        end
        wr(OFS_IND_STROBE, 8'h07);
        wt(1);
        chk("ind_port.req", 16'h0000, 16'(ind_port.req));
        rc(OFS_IND_STROBE, 8'h07);
        s = 8'h00;
        for (int k = 13; k >= 0; k--) begin
            wr(OFS_STD_SEL, 8'(k));
            s = k[0] ? s : 8'(k);
            wt(2);
            chk("std_select", 16'(s), 16'(std_select));
            chk("std_forced", 16'(s != 8'h00), 16'(std_forced));
            rc(OFS_STD_SEL, s);
        end
        wr(OFS_TIMING_REV, 8'h01);
        rc(OFS_TIMING_REV, 8'h01);
        chk("timing_rev_old", 16'h0001, 16'(timing_rev_old));
        wr(OFS_CP_ON, 8'h02);
        wr(OFS_CP_OFF, 8'h02);
        for (int f = 0; f < 4; f++) begin
            frame(f < 2);
            chk("cp_present", 16'(f > 0 && f < 3), 16'(cp_present));
        end
        rc(OFS_IRQ_STATUS, 8'h01 << IRQ_CP_BIT);
        wr(OFS_PATCH_RUN, 8'h01);
        wt(3);
        chk("restarts", 16'h0000, 16'(n_rst));
        wr(OFS_PATCH_LOAD, 8'h5A);
        wr(OFS_PATCH_RUN, 8'h01);
        wt(3);
        chk("patch bytes", 16'h0001, 16'(n_patch));
        chk("patch byte", 16'h005A, 16'(last_patch));
        chk("restarts", 16'h0001, 16'(n_rst));
        final_report();
    end
endmodule : vdh_host_regs_tb
